// File: hdl/cmc_top.sv
// Comparator mode control: registers, pin muxing, settling and change interrupt
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Eight comparator configurations selected by a three-bit configuration field.
// - Port A direction register controls pin direction in every configuration.
// - After a configuration change, outputs are invalid until mode-change delay ends.
// - Configuration 011: pins 0,1 inverting inputs, pin 2 shared non-inverting.
// - Output low when non-inverting below inverting, high when above.
// - Configuration 010: internal reference feeds both non-inverting inputs.
// - Output valid only after response time; reference change uses its settling.
// - Both comparator outputs readable in control register; writes ignored.
// - Configuration 110: raw comparator outputs drive pins 3 and 4.
// - Direction bits still enable pin 3 and 4 drivers in that configuration.
// - Port data read returns zero for pins used as analog inputs.
// - Change flag sets regardless of individual or global enables.
module cmc_top
    import cmc_pkg::*;
(
    input wire logic clk_i,                   // 125 MHz clock
    input wire logic sys_rst_i,               // Async reset, active high
    input wire logic psel_i,                  // APB select
    input wire logic penable_i,               // APB enable
    input wire logic pwrite_i,                // APB write
    input wire logic [7:0] paddr_i,           // APB byte address
    input wire logic [31:0] pwdata_i,         // APB write data
    output logic [31:0] prdata_o,             // APB read data
    output logic pready_o,                    // APB ready
    output logic pslverr_o,                   // APB error, unmapped address
    input wire logic [1:0] cmp_raw_i,         // Analog comparator outputs
    input wire logic [cmc_pkg::CMC_NPIN-1:0] pad_in_i,   // Port A pin levels
    output logic [cmc_pkg::CMC_NPIN-1:0] pad_out_o,      // Port A pin drive value
    output logic [cmc_pkg::CMC_NPIN-1:0] pad_oe_o,       // Port A pin drive enable
    output logic [cmc_pkg::CMC_NPIN-1:0] analog_sel_o,   // Pin routed to comparator
    output logic vref_sel_o,                  // Internal reference to both non-inverting
    output logic cmp_on_o,                    // Comparators powered
    output logic irq_o                        // Change interrupt, level
);
    import cmc_pkg::*;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic setup;
    logic access;
    logic mapped;
    logic wr_ctrl;
    logic wr_dir;
    logic wr_data;
    logic wr_ena;
    logic rd_ctrl;
    logic rd_flag;

    assign setup = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    assign mapped = (paddr_i == CMC_CTRL_OFS) | (paddr_i == CMC_DIR_OFS)
                  | (paddr_i == CMC_DATA_OFS) | (paddr_i == CMC_FLAG_OFS)
                  | (paddr_i == CMC_ENA_OFS);
    assign wr_ctrl = access & pwrite_i & (paddr_i == CMC_CTRL_OFS);
    assign wr_dir = access & pwrite_i & (paddr_i == CMC_DIR_OFS);
    assign wr_data = access & pwrite_i & (paddr_i == CMC_DATA_OFS);
    assign wr_ena = access & pwrite_i & (paddr_i == CMC_ENA_OFS);
    assign rd_ctrl = access & ~pwrite_i & (paddr_i == CMC_CTRL_OFS);
    assign rd_flag = access & ~pwrite_i & (paddr_i == CMC_FLAG_OFS);

    // Read data is captured in the setup cycle, so access completes at once
    assign pready_o = access;
    assign pslverr_o = access & ~mapped;

    // ************************************************************
    // Synchronisers
    // ************************************************************
    logic [1:0] cmp_s;
    logic [CMC_NPIN-1:0] pad_s;

    // Raw outputs are asynchronous to the core clock
    cmc_sync #(.W(2)) u_sync_cmp (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(cmp_raw_i),
        .q_o(cmp_s)
    );

    cmc_sync #(.W(CMC_NPIN)) u_sync_pad (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(pad_in_i),
        .q_o(pad_s)
    );

    // ************************************************************
    // Control registers
    // ************************************************************
    cmc_mode_t cfg_q;
    logic [CMC_NPIN-1:0] dir_q;
    logic [CMC_NPIN-1:0] latch_q;
    logic [7:0] ena_q;
    logic flag_q;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cfg_q <= cmc_mode_t'(CMC_CFG_RST);
        else if (wr_ctrl)
            cfg_q <= cmc_mode_t'(pwdata_i[CMC_CFG_LSB +: 3]);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            dir_q <= CMC_DIR_RST;
        else if (wr_dir)
            dir_q <= pwdata_i[CMC_NPIN-1:0];
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            latch_q <= CMC_LATCH_RST;
        else if (wr_data)
            latch_q <= pwdata_i[CMC_NPIN-1:0];
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ena_q <= CMC_ENA_RST;
        else if (wr_ena)
            ena_q <= pwdata_i[7:0];
    end

    // ************************************************************
    // Configuration decode
    // ************************************************************
    logic [CMC_NPIN-1:0] an_mask;

    always_comb
    begin
        unique case (cfg_q)
            CMC_M_RESET: an_mask = CMC_AN_RESET;
            CMC_M_MUX1: an_mask = CMC_AN_MUX1;
            CMC_M_VREF: an_mask = CMC_AN_VREF;
            CMC_M_COMMON: an_mask = CMC_AN_COMMON;
            CMC_M_INDEP: an_mask = CMC_AN_INDEP;
            CMC_M_ONE: an_mask = CMC_AN_ONE;
            CMC_M_COM_OUT: an_mask = CMC_AN_COM_OUT;
            CMC_M_OFF: an_mask = CMC_AN_OFF;
        endcase
    end

    assign analog_sel_o = an_mask;
    assign vref_sel_o = (cfg_q == CMC_M_VREF);
    assign cmp_on_o = (cfg_q != CMC_M_RESET) & (cfg_q != CMC_M_OFF);

    // ************************************************************
    // Pin drivers
    // ************************************************************
    logic com_out;

    assign com_out = (cfg_q == CMC_M_COM_OUT);

    // Unsynchronised on purpose: pins follow the comparator with no clock delay
    always_comb
    begin
        pad_out_o = latch_q;
        if (com_out)
        begin
            pad_out_o[3] = cmp_raw_i[0];
            pad_out_o[4] = cmp_raw_i[1];
        end
    end

    // Direction bit 1 means input; it still gates the mux driver
    assign pad_oe_o = ~dir_q;

    // ************************************************************
    // Settling timer
    // ************************************************************
    logic [CMC_CNT_W-1:0] settle_q;
    logic cfg_chg;
    logic ref_chg;
    logic out_valid;
    cmc_mode_t new_cfg;

    // Configuration as written, compared with the one in force
    assign new_cfg = cmc_mode_t'(pwdata_i[CMC_CFG_LSB +: 3]);
    assign cfg_chg = wr_ctrl & (new_cfg != cfg_q);
    assign ref_chg = (new_cfg == CMC_M_VREF) | (cfg_q == CMC_M_VREF);
    assign out_valid = (settle_q == '0);

    // Reference change waits the reference settling time, 50 cycles shorter than mode change plus response
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            settle_q <= CMC_CNT_W'(CMC_MODE_CHG_CYC);
        else if (cfg_chg && ref_chg)
            settle_q <= CMC_CNT_W'(CMC_VREF_CYC);
        else if (cfg_chg)
            settle_q <= CMC_CNT_W'(CMC_MODE_CHG_CYC + CMC_RESP_CYC);
        else if (!out_valid)
            settle_q <= settle_q - CMC_CNT_W'(1);
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0;
        unique case (paddr_i)
            CMC_CTRL_OFS:
            begin
                rd_mux[CMC_CFG_LSB +: 3] = cfg_q;
                rd_mux[CMC_VALID_BIT] = out_valid;
                rd_mux[CMC_OUT1_BIT] = cmp_s[0];
                rd_mux[CMC_OUT2_BIT] = cmp_s[1];
            end
            CMC_DIR_OFS: rd_mux[CMC_NPIN-1:0] = dir_q;
            CMC_DATA_OFS: rd_mux[CMC_NPIN-1:0] = pad_s & ~an_mask;
            CMC_FLAG_OFS: rd_mux[CMC_FLAG_BIT] = flag_q;
            CMC_ENA_OFS: rd_mux[7:0] = ena_q;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            prdata_o <= 32'h0;
        else if (setup && !pwrite_i)
            prdata_o <= rd_mux;
    end

    // ************************************************************
    // Change detection and interrupt
    // ************************************************************
    logic [1:0] seen_q;
    logic mismatch;
    logic flag_clr;

    // Latch what software actually saw, so a later edge is never lost
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            seen_q <= 2'h0;
        else if (rd_ctrl)
            seen_q <= prdata_o[CMC_OUT2_BIT:CMC_OUT1_BIT];
    end

    // Settling hides glitches, but software should still mask during changes
    assign mismatch = out_valid & cmp_on_o & (cmp_s != seen_q);
    assign flag_clr = rd_flag & prdata_o[CMC_FLAG_BIT];

    // Set wins over clear; enables do not gate the flag
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            flag_q <= 1'b0;
        else if (mismatch)
            flag_q <= 1'b1;
        else if (flag_clr)
            flag_q <= 1'b0;
    end

    assign irq_o = flag_q & ena_q[CMC_IE_BIT] & ena_q[CMC_PERIPHERAL_INT_ENABLE_BIT] & ena_q[CMC_GIE_BIT];

    // ************************************************************
    // Assertions
    // ************************************************************
    // Raw output high means non-inverting above inverting
    a_pin3_mux: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        com_out |-> (pad_out_o[3] == cmp_raw_i[0]) && (pad_out_o[4] == cmp_raw_i[1]))
        else $error("pins 3 and 4 do not carry the comparator outputs");

    a_pin_latch: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !com_out |-> (pad_out_o == latch_q) && (pad_oe_o == ~dir_q))
        else $error("pin drive does not follow latch and direction");

    a_oe_in_mux: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (com_out && dir_q[3]) |-> !pad_oe_o[3])
        else $error("pin 3 driven although set as input");

    sequence s_cfg_change;
        wr_ctrl && (pwdata_i[2:0] != cfg_q) && (pwdata_i[2:0] != 3'h2) && (cfg_q != 3'h2);
    endsequence

    a_cfg_invalid: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        s_cfg_change |=> (!out_valid && !mismatch)[*8])
        else $error("output treated valid right after a configuration change");

    a_settle_len: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        $fell(out_valid) |-> (!out_valid)[*8])
        else $error("settling ended too soon");

    a_vref_route: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        vref_sel_o |-> (cfg_q == CMC_M_VREF) && cmp_on_o)
        else $error("reference routed outside configuration 010");

    a_common_pins: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (cfg_q == CMC_M_COMMON) |-> (analog_sel_o == 5'h07))
        else $error("configuration 011 pin routing wrong");

    a_out_read: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (setup && !pwrite_i && paddr_i == CMC_CTRL_OFS)
        |=> prdata_o[7:6] == $past(cmp_s))
        else $error("control read does not show comparator outputs");

    a_analog_zero: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (setup && !pwrite_i && paddr_i == CMC_DATA_OFS)
        |=> (prdata_o[4:0] & $past(an_mask)) == 5'h00)
        else $error("analog pin reads nonzero");

    a_flag_set: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        mismatch |=> flag_q)
        else $error("change flag not set on mismatch");

    a_sync_delay: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ##2 cmp_s == $past(cmp_raw_i, 2))
        else $error("comparator outputs not two-stage synchronised");

    a_irq_cause: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        irq_o |-> flag_q && ena_q[7])
        else $error("interrupt without flag");

endmodule : cmc_top

`default_nettype wire

// File: hdl/cmc_pkg.sv
// Package of constants and types for the comparator mode control block
package cmc_pkg;

    // ************************************************************
    // Register map, byte addresses on the APB
    // ************************************************************
    localparam logic [7:0] CMC_CTRL_OFS = 8'h00;
    localparam logic [7:0] CMC_DIR_OFS = 8'h04;
    localparam logic [7:0] CMC_DATA_OFS = 8'h08;
    localparam logic [7:0] CMC_FLAG_OFS = 8'h0c;
    localparam logic [7:0] CMC_ENA_OFS = 8'h10;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CMC_CFG_LSB = 0;
    localparam int CMC_VALID_BIT = 3;
    localparam int CMC_OUT1_BIT = 6;
    localparam int CMC_OUT2_BIT = 7;
    localparam int CMC_FLAG_BIT = 0;
    localparam int CMC_IE_BIT = 0;
    localparam int CMC_PERIPHERAL_INT_ENABLE_BIT = 6;
    localparam int CMC_GIE_BIT = 7;
    localparam int CMC_NPIN = 5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [2:0] CMC_CFG_RST = 3'h0;
    localparam logic [4:0] CMC_DIR_RST = 5'h1f;
    localparam logic [4:0] CMC_LATCH_RST = 5'h00;
    localparam logic [7:0] CMC_ENA_RST = 8'h00;

    // ************************************************************
    // Configurations and their analog pin masks
    // ************************************************************
    typedef enum logic [2:0] {
        CMC_M_RESET = 3'h0,
        CMC_M_MUX1 = 3'h1,
        CMC_M_VREF = 3'h2,
        CMC_M_COMMON = 3'h3,
        CMC_M_INDEP = 3'h4,
        CMC_M_ONE = 3'h5,
        CMC_M_COM_OUT = 3'h6,
        CMC_M_OFF = 3'h7
    } cmc_mode_t;

    localparam logic [4:0] CMC_AN_RESET = 5'h0f;
    localparam logic [4:0] CMC_AN_MUX1 = 5'h0f;
    localparam logic [4:0] CMC_AN_VREF = 5'h0f;
    localparam logic [4:0] CMC_AN_COMMON = 5'h07;
    localparam logic [4:0] CMC_AN_INDEP = 5'h0f;
    localparam logic [4:0] CMC_AN_ONE = 5'h06;
    localparam logic [4:0] CMC_AN_COM_OUT = 5'h07;
    localparam logic [4:0] CMC_AN_OFF = 5'h00;

    // ************************************************************
    // Timing: figures in ns, counts at 125 MHz
    // ************************************************************
    localparam int CMC_CLK_NS = 8;
    localparam int CMC_MODE_CHG_NS = 10000;
    localparam int CMC_RESP_NS = 400;
    localparam int CMC_VREF_SETTLE_NS = 10000;
    localparam int CMC_MODE_CHG_CYC = (CMC_MODE_CHG_NS + CMC_CLK_NS - 1) / CMC_CLK_NS;
    localparam int CMC_RESP_CYC = (CMC_RESP_NS + CMC_CLK_NS - 1) / CMC_CLK_NS;
    localparam int CMC_VREF_CYC = (CMC_VREF_SETTLE_NS + CMC_CLK_NS - 1) / CMC_CLK_NS;
    localparam int CMC_CNT_W = 12;

endpackage : cmc_pkg

// File: hdl/cmc_sync.sv
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module cmc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,          // System clock
    input wire logic sys_rst_i,      // Async reset, active high
    input wire logic [W-1:0] d_i,    // Asynchronous level
    output logic [W-1:0] q_o         // Synchronised level
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule : cmc_sync

`default_nettype wire

// File: sim/cmc_analog_model.sv
// Analog side model: comparator inputs, internal reference and pin levels
`timescale 1ns/1ps
`default_nettype none

module cmc_analog_model #(
    parameter int RESP_NS = 400,
    parameter int VREF_MV = 1650
) (
    input wire logic [4:0] analog_sel_i, // Pins routed to comparators
    input wire logic vref_sel_i,         // Internal reference selected
    input wire logic cmp_on_i,           // Comparators powered
    input wire logic [4:0] pad_out_i,    // Pin drive value
    input wire logic [4:0] pad_oe_i,     // Pin drive enable
    output logic [1:0] cmp_raw_o,        // Comparator outputs
    output logic [4:0] pad_lvl_o         // Resolved pin levels
);
    int mv [5] = '{0, 0, 0, 0, 0};
    logic [1:0] cmp_d;
    logic [1:0] cmp_q = 2'h0;

    task automatic set_pin(input int n, input int v);
        mv[n] = v;
    endtask : set_pin

    always_comb
    begin
        int p1;
        int p2;
        p2 = mv[2];
        p1 = (analog_sel_i == 5'h07) ? mv[2] : mv[3];
        if (vref_sel_i)
        begin
            p1 = VREF_MV;
            p2 = VREF_MV;
        end
        // A powered-down comparator gives low, never the stale level
        cmp_d = cmp_on_i ? {p2 > mv[1], p1 > mv[0]} : 2'h0;
        for (int i = 0; i < 5; i++)
            pad_lvl_o[i] = pad_oe_i[i] ? pad_out_i[i] : (mv[i] > 1650);
    end

    // Output only follows a new input after the response time
    // Starts low so the block never sees an unknown level out of reset
    always @(cmp_d)
        cmp_q <= #(RESP_NS) cmp_d;

    assign cmp_raw_o = cmp_q;

endmodule : cmc_analog_model
`default_nettype wire

// File: sim/cmc_top_test.sv
// Self-checking bench for the comparator mode control block
`timescale 1ns/1ps
`default_nettype none

module cmc_top_test;
    import cmc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, vref_sel, cmp_on, irq, err;
    logic [1:0] cmp_raw;
    logic [4:0] pad_in, pad_out, pad_oe, analog_sel;
    logic [4:0] an_m [8] = '{5'h0f, 5'h0f, 5'h0f, 5'h07, 5'h0f, 5'h06, 5'h07, 5'h00};
    logic [2:0] cfg_m = 3'h0;
    logic [4:0] dir_m = 5'h1f;
    logic [4:0] lat_m = 5'h00;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 16;
    int mv [5] = '{0, 0, 0, 0, 0};

    cmc_top cmc_top_i (.clk_i(clk), .sys_rst_i(sys_rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cmp_raw_i(cmp_raw), .pad_in_i(pad_in),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .analog_sel_o(analog_sel),
        .vref_sel_o(vref_sel), .cmp_on_o(cmp_on), .irq_o(irq));
    cmc_analog_model cmc_analog_model_i (.analog_sel_i(analog_sel), .vref_sel_i(vref_sel),
        .cmp_on_i(cmp_on), .pad_out_i(pad_out), .pad_oe_i(pad_oe), .cmp_raw_o(cmp_raw),
        .pad_lvl_o(pad_in));

    initial
    begin
        forever #4 clk = ~clk;
    end

    // ****************************************
    // Bus tasks and reference model
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request held until pready is seen high at a rising edge
    // Called just after a rising edge; returns one edge after release so effects are settled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(nm, e & m, rd & m);
    endtask : rdc

    task automatic pin(input int n, input int v);
        mv[n] = v;
        cmc_analog_model_i.set_pin(n, v);
    endtask : pin

    function automatic logic [1:0] exp_cmp();
        int p1;
        int p2;
        p2 = (cfg_m == 3'h2) ? 1650 : mv[2];
        p1 = (cfg_m == 3'h3 || cfg_m == 3'h6) ? mv[2] : p2;
        p1 = (cfg_m == 3'h3 || cfg_m == 3'h6 || cfg_m == 3'h2) ? p1 : mv[3];
        return {p2 > mv[1], p1 > mv[0]};
    endfunction : exp_cmp

    function automatic logic [31:0] exp_data();
        logic [4:0] ext;
        for (int i = 0; i < 5; i++)
            ext[i] = mv[i] > 1650;
        return 32'(((~dir_m & lat_m) | (dir_m & ext)) & ~an_m[cfg_m]);
    endfunction : exp_data

    task automatic settle(input logic [2:0] m, input int n);
        apb(1'b1, CMC_CTRL_OFS, 32'(m));
        cfg_m = m;
        repeat (n - 30) @(posedge clk);
        rdc("ctrl early", CMC_CTRL_OFS, 32'(m), 32'h0f);
        repeat (40) @(posedge clk);
        rdc("ctrl settled", CMC_CTRL_OFS, 32'h8 | 32'(m), 32'h0f);
    endtask : settle

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        pin(0, 1000);
        pin(1, 2000);
        pin(2, 1500);
        pin(3, 500);
        rdc("ctrl reset", CMC_CTRL_OFS, 32'h0, 32'hff);
        rdc("dir reset", CMC_DIR_OFS, 32'h1f, 32'hff);
        rdc("ena reset", CMC_ENA_OFS, 32'h0, 32'hff);
        chk("pad_oe", 32'h0, 32'(pad_oe));
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        chk("unmapped", 32'h0, rd);
        // Change interrupt stays disabled through all mode changes
        for (int i = 1; i <= 8; i++)
        begin
            apb(1'b1, CMC_CTRL_OFS, 32'(i % 8));
            cfg_m = 3'(i % 8);
            chk("analog_sel", 32'(an_m[cfg_m]), 32'(analog_sel));
            chk("vref_sel", 32'(cfg_m == 3'h2), 32'(vref_sel));
            chk("cmp_on", 32'(cfg_m != 3'h0 && cfg_m != 3'h7), 32'(cmp_on));
            rdc("ctrl mode", CMC_CTRL_OFS, 32'(cfg_m), 32'h0f);
        end
        settle(3'h3, 1300);
        settle(3'h2, 1250);
        rdc("ctrl vref", CMC_CTRL_OFS, {24'h0, exp_cmp(), 3'h1, cfg_m}, 32'hcf);
        settle(3'h3, 1250);
        apb(1'b1, CMC_CTRL_OFS, 32'hcb);
        rdc("ctrl ro", CMC_CTRL_OFS, {24'h0, exp_cmp(), 3'h1, cfg_m}, 32'hcf);
        // Software start-up order
        apb(1'b1, CMC_DIR_OFS, 32'h07);
        dir_m = 5'h07;
        chk("pad_oe", 32'h18, 32'(pad_oe));
        apb(1'b0, CMC_CTRL_OFS, 32'h0);
        apb(1'b0, CMC_FLAG_OFS, 32'h0);
        apb(1'b1, CMC_ENA_OFS, 32'hc1);
        chk("irq idle", 32'h0, 32'(irq));
        pin(0, 2500);
        repeat (70) @(posedge clk);
        chk("irq change", 32'h1, 32'(irq));
        rdc("ctrl new", CMC_CTRL_OFS, {24'h0, exp_cmp(), 3'h1, cfg_m}, 32'hcf);
        rdc("flag set", CMC_FLAG_OFS, 32'h1, 32'h1);
        rdc("flag clr", CMC_FLAG_OFS, 32'h0, 32'h1);
        chk("irq clr", 32'h0, 32'(irq));
        apb(1'b1, CMC_ENA_OFS, 32'h01);
        pin(0, 1000);
        repeat (70) @(posedge clk);
        chk("irq gated", 32'h0, 32'(irq));
        rdc("flag gated", CMC_FLAG_OFS, 32'h1, 32'h1);
        apb(1'b1, CMC_ENA_OFS, 32'h00);
        apb(1'b1, CMC_CTRL_OFS, 32'h6);
        cfg_m = 3'h6;
        repeat (60) @(posedge clk);
        chk("pin drive", 32'(exp_cmp()), 32'(pad_out[4:3]));
        pin(1, 1000);
        repeat (60) @(posedge clk);
        chk("pin drive", 32'(exp_cmp()), 32'(pad_out[4:3]));
        chk("pad_oe", 32'h18, 32'(pad_oe));
        apb(1'b1, CMC_DIR_OFS, 32'h1f);
        chk("pad_oe", 32'h0, 32'(pad_oe));
        apb(1'b1, CMC_CTRL_OFS, 32'h3);
        cfg_m = 3'h3;
        lat_m = 5'($random(seed));
        apb(1'b1, CMC_DATA_OFS, 32'(lat_m));
        for (int j = 0; j < 8; j++)
        begin
            dir_m = 5'($random(seed));
            for (int i = 0; i < 5; i++)
                pin(i, ($random(seed) & 1) ? 3000 : 300);
            apb(1'b1, CMC_DIR_OFS, 32'(dir_m));
            chk("pad_oe", 32'(dir_m ^ 5'h1f), 32'(pad_oe));
            repeat (4) @(posedge clk);
            rdc("data", CMC_DATA_OFS, exp_data(), 32'h1f);
        end
        wrap_up();
    end

endmodule : cmc_top_test
`default_nettype wire
